// >>> design/prot_cfg_pkg.sv
// Constants of the protection setup store: field layout, defaults, codes.
// Assumes a decoded command stream from the serial front end.
package prot_cfg_pkg;
   localparam int OV_LSB      = 14;
   localparam int UV_LSB      = 12;
   localparam int OC_LSB      = 10;
   localparam int LC_LSB      = 8;
   localparam int CELL_BIT    = 7;
   localparam int BLOCK_BIT   = 6;
   localparam int CHG_SW_BIT  = 10;
   localparam int DIS_SW_BIT  = 11;
   localparam int STAT_B2     = 2;
   localparam logic [15:0] DEF_4CELL = 16'h33C0;
   localparam logic [15:0] DEF_3CELL = 16'h0340;
   localparam logic [15:0] CTRL_RST  = 16'h0000;
   localparam logic [15:0] OWN_MASK  = 16'hFFC0;
   // Thresholds in millivolts
   localparam logic [15:0] OV_MV [4] = '{16'h1068, 16'h109A, 16'h10CC, 16'h10FE};
   localparam logic [15:0] UV4_MV0   = 16'h079E;
   localparam logic [15:0] UV3_MV0   = 16'h08CA;
   localparam logic [15:0] UV_STEP   = 16'h0064;
   localparam logic [15:0] OC_MV0    = 16'h004B;
   localparam logic [15:0] OC_STEP   = 16'h0019;
   localparam logic [15:0] LC_MV0    = 16'h01F4;
   localparam logic [15:0] LC_STEP   = 16'h012C;
   localparam int STORE_US = 5000;
   localparam int CLK_MHZ  = 40;
   localparam int STORE_CYC = STORE_US * CLK_MHZ;
endpackage

// >>> design/battery_protect_config_store.sv
// Setup word store with shadow copy, control word and wake sequencing.
// Commands arrive as one-cycle decoded strobes from the serial engine.
`timescale 1ns/1ps
module battery_protect_config_store #(
   parameter bit FOUR_CELL = 1'b1,
   parameter int STORE_CYCLES = prot_cfg_pkg::STORE_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        wake_supply_level,
   input  wire logic        sleep_req,
   input  wire logic        setup_word_write_cmd,
   input  wire logic        control_word_write_cmd,
   input  wire logic        write_enable_cmd,
   input  wire logic        array_write_cmd,
   input  wire logic [15:0] wr_data,
   input  wire logic        low_cell_flag,
   input  wire logic        overcharge_flag,
   output logic             awake,
   output logic [15:0]      protection_setup_word,
   output logic [15:0]      control_word,
   output logic             charge_switch_ctrl,
   output logic             discharge_switch_ctrl,
   output logic             store_busy,
   output logic             status_bit2,
   output logic [15:0]      overcharge_mv,
   output logic [15:0]      undervoltage_mv,
   output logic [15:0]      overcurrent_mv,
   output logic [15:0]      low_cell_mv,
   output logic             low_cell_block_on,
   output logic             four_cells
);
   initial
   begin
      if (STORE_CYCLES < 1)
         $error("STORE_CYCLES must be at least one");
   end

   typedef enum logic [1:0] {
      ST_SLEEP = 2'b00,
      ST_RUN   = 2'b01,
      ST_STORE = 2'b10
   } state_t;

   state_t      state_q;
   state_t      state_d;
   logic [15:0] shadow_q;
   logic [15:0] sram_q;
   logic [15:0] ctrl_q;
   logic        write_enable_cmd_q;
   logic [31:0] cnt_q;
   logic        boot_q;

   wire logic [15:0] factory_def = FOUR_CELL ? prot_cfg_pkg::DEF_4CELL
                                             : prot_cfg_pkg::DEF_3CELL;
   wire logic run_mode   = (state_q != ST_SLEEP);
   wire logic wake_now   = (state_q == ST_SLEEP) && wake_supply_level;
   wire logic start_store = (state_q == ST_RUN) && array_write_cmd && write_enable_cmd_q;
   wire logic store_done  = (state_q == ST_STORE) && (cnt_q == 32'h0000_0000);

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_SLEEP:
         begin
            if (wake_now)
               state_d = ST_RUN;
         end
         ST_RUN:
         begin
            if (start_store)
               state_d = ST_STORE;
            else if (sleep_req)
               state_d = ST_SLEEP;
         end
         ST_STORE:
         begin
            if (store_done)
               state_d = ST_RUN;
         end
         default:
            state_d = ST_SLEEP;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         state_q <= ST_SLEEP;
      else
         state_q <= state_d;
   end

   // Factory value loads shadow once after reset
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         boot_q <= 1'b1;
      else
         boot_q <= 1'b0;
   end

   // Factory default; shadow store; no array path
   always_ff @(posedge sys_clk)
   begin
      if (boot_q)
         shadow_q <= factory_def;
      else if (start_store)
         shadow_q <= sram_q;
   end

   // Recall on wake; setup write to copy only; hold
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         sram_q <= 16'h0000;
      else if (boot_q || wake_now)
         sram_q <= boot_q ? factory_def : shadow_q;
      else if (state_q == ST_RUN && setup_word_write_cmd && !start_store)
         sram_q <= wr_data & prot_cfg_pkg::OWN_MASK;
   end

   // Control cleared at wake
   // Also cleared on the edge that enters sleep, so switches drop at once
   always_ff @(posedge sys_clk)
   begin
      if (rst || wake_now || !run_mode || state_d == ST_SLEEP)
         ctrl_q <= prot_cfg_pkg::CTRL_RST;
      else if (control_word_write_cmd)
         ctrl_q <= wr_data;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst || !run_mode || start_store)
         write_enable_cmd_q <= 1'b0;
      else if (write_enable_cmd)
         write_enable_cmd_q <= 1'b1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         cnt_q <= 32'h0000_0000;
      else if (start_store)
         cnt_q <= 32'(STORE_CYCLES - 1);
      else if (state_q == ST_STORE && cnt_q != 32'h0000_0000)
         cnt_q <= cnt_q - 32'h0000_0001;
   end

   wire logic [1:0] ov_code = sram_q[prot_cfg_pkg::OV_LSB +: 2];
   wire logic [1:0] uv_code = sram_q[prot_cfg_pkg::UV_LSB +: 2];
   wire logic [1:0] oc_code = sram_q[prot_cfg_pkg::OC_LSB +: 2];
   wire logic [1:0] lc_code = sram_q[prot_cfg_pkg::LC_LSB +: 2];

   function automatic logic [15:0] step_mv(input logic [15:0] base,
                                            input logic [15:0] step,
                                            input logic [1:0]  code);
      step_mv = base + step * {14'h0000, code};
   endfunction

   assign awake                 = run_mode;
   assign protection_setup_word = sram_q;
   assign control_word          = ctrl_q;
   assign charge_switch_ctrl    = ctrl_q[prot_cfg_pkg::CHG_SW_BIT];
   assign discharge_switch_ctrl = ctrl_q[prot_cfg_pkg::DIS_SW_BIT];
   assign store_busy            = (state_q == ST_STORE);
   assign overcharge_mv   = prot_cfg_pkg::OV_MV[ov_code];
   assign undervoltage_mv = step_mv(FOUR_CELL ? prot_cfg_pkg::UV4_MV0
                                              : prot_cfg_pkg::UV3_MV0,
                                    prot_cfg_pkg::UV_STEP, uv_code);
   assign overcurrent_mv  = step_mv(prot_cfg_pkg::OC_MV0, prot_cfg_pkg::OC_STEP, oc_code);
   assign low_cell_mv     = step_mv(prot_cfg_pkg::LC_MV0, prot_cfg_pkg::LC_STEP, lc_code);
   // Block active when bit is zero
   assign low_cell_block_on = ~sram_q[prot_cfg_pkg::BLOCK_BIT];
   assign four_cells = sram_q[prot_cfg_pkg::CELL_BIT];
   assign status_bit2 = overcharge_flag | (low_cell_block_on & low_cell_flag);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   wake_clear_a: assert property (wake_now |=> ctrl_q == 16'h0000 && sram_q == $past(shadow_q))
      else $error("wake did not clear control or recall shadow");

   sleep_hold_a: assert property (state_q == ST_SLEEP && !wake_supply_level |=> !awake)
      else $error("left sleep without wake level");

   wake_run_a: assert property (wake_now |=> awake)
      else $error("wake level did not wake the block");

   switch_off_a: assert property (wake_now |=> !charge_switch_ctrl && !discharge_switch_ctrl)
      else $error("switch drive on after wake");

   store_copy_a: assert property (start_store |=> shadow_q == $past(sram_q) && store_busy)
      else $error("store did not copy working word");

   store_len_a: assert property (start_store |=> cnt_q == 32'(STORE_CYCLES - 1))
      else $error("store counter not loaded");

   store_end_a: assert property (store_done |=> !store_busy)
      else $error("store did not end");

   write_enable_cmd_arm_a: assert property (run_mode && write_enable_cmd && !start_store |=> write_enable_cmd_q)
      else $error("write enable not armed");

   write_enable_cmd_need_a: assert property (state_q == ST_RUN && array_write_cmd && !write_enable_cmd_q |=> !store_busy)
      else $error("store started without write enable");

   setup_only_a: assert property (setup_word_write_cmd && !start_store && !boot_q |=> $stable(shadow_q))
      else $error("setup write touched shadow");

   setup_take_a: assert property (state_q == ST_RUN && setup_word_write_cmd && !start_store
      |=> sram_q == ($past(wr_data) & prot_cfg_pkg::OWN_MASK))
      else $error("setup write not taken");

   shadow_keep_a: assert property (!start_store && !boot_q |=> $stable(shadow_q))
      else $error("shadow changed outside a store");

   store_hold_a: assert property (store_busy && !boot_q |=> $stable(sram_q))
      else $error("working word changed during store");

   ctrl_sleep_a: assert property (!run_mode |-> ctrl_q == 16'h0000 && !charge_switch_ctrl)
      else $error("control word nonzero in sleep");

   ctrl_take_a: assert property (run_mode && control_word_write_cmd && state_d != ST_SLEEP
      |=> control_word == $past(wr_data))
      else $error("control write not taken");

   boot_load_a: assert property (boot_q |=> sram_q == factory_def && shadow_q == factory_def)
      else $error("factory word not loaded");

   cell_boot_a: assert property (boot_q |=> four_cells == FOUR_CELL)
      else $error("default cell count wrong");

   low_bits_a: assert property (sram_q[5:0] == 6'h00)
      else $error("unused setup bits not zero");

   block_bit_a: assert property (sram_q[6] |-> !low_cell_block_on)
      else $error("low cell block on with bit set");

   stat_comb_a: assert property (sram_q[6] |-> status_bit2 == overcharge_flag)
      else $error("status bit 2 wrong with block off");

   oc_range_a: assert property (oc_code == 2'b11 |-> overcurrent_mv == 16'h0096)
      else $error("overcurrent top code wrong");

   oc_base_a: assert property (oc_code == 2'b00 |-> overcurrent_mv == 16'h004B)
      else $error("overcurrent base code wrong");

   ov_range_a: assert property (ov_code == 2'b00 |-> overcharge_mv == 16'h1068)
      else $error("overcharge base code wrong");

   ov_top_a: assert property (ov_code == 2'b11 |-> overcharge_mv == 16'h10FE)
      else $error("overcharge top code wrong");

   uv_top_a: assert property (uv_code == 2'b11
      |-> undervoltage_mv == (FOUR_CELL ? 16'h08CA : 16'h09F6))
      else $error("undervoltage top code wrong");

   lc_base_a: assert property (lc_code == 2'b00 |-> low_cell_mv == 16'h01F4)
      else $error("low cell base code wrong");

   // Wake from sleep
   wake_c:   cover property (wake_now);
   // Store runs for a while
   store_c:  cover property (start_store ##1 store_busy [*2]);
   // Setup word written
   write_c:  cover property (run_mode && setup_word_write_cmd);
   // Sleep requested while running
   sleep_c:  cover property (state_q == ST_RUN && sleep_req);
   // Unarmed array write refused
   refuse_c: cover property (state_q == ST_RUN && array_write_cmd && !write_enable_cmd_q);
endmodule

// >>> test/host_model.sv
// Host side: drives one decoded command strobe and its data word per call.
// Assumes the store samples the strobes on the rising edge.
`timescale 1ns/1ps
module host_model #(
   parameter bit FOUR_CELL = 1'b1
) (
   input  wire logic        sys_clk,
   output logic      [3:0]  cmd_q,
   output logic      [15:0] data_q
);
   initial cmd_q = 4'h0;
   initial data_q = 16'h0000;
   task automatic send(input int kind, input logic [15:0] d);
      @(posedge sys_clk);
      cmd_q <= 4'h1 << kind;
      data_q <= FOUR_CELL ? d : (d & 16'hff7f);
      @(posedge sys_clk);
      cmd_q <= 4'h0;
   endtask
endmodule

// >>> test/battery_protect_config_store_tb.sv
// Self-checking bench: setup word store against an integer model.
// Assumes the host model drives every command strobe.
`timescale 1ns/1ps
module battery_protect_config_store_tb;
   logic        sys_clk, rst, wake_supply_level, sleep_req, low_cell_flag, overcharge_flag;
   logic [3:0]  cmd;
   logic [15:0] wr_data, protection_setup_word, control_word;
   logic [15:0] overcharge_mv, undervoltage_mv, overcurrent_mv, low_cell_mv;
   logic        awake, charge_switch_ctrl, discharge_switch_ctrl, store_busy;
   logic        status_bit2, low_cell_block_on, four_cells;
   logic [15:0] word3, uv3;
   int          n_mismatch, compares, seed, sw, sh, ct, aw, r, i;

   battery_protect_config_store #(.FOUR_CELL(1'b1), .STORE_CYCLES(4)) u_dut (
      .sys_clk, .rst, .wake_supply_level, .sleep_req, .setup_word_write_cmd(cmd[0]),
      .control_word_write_cmd(cmd[1]), .write_enable_cmd(cmd[2]),
      .array_write_cmd(cmd[3]), .wr_data, .low_cell_flag, .overcharge_flag, .awake,
      .protection_setup_word, .control_word, .charge_switch_ctrl, .discharge_switch_ctrl,
      .store_busy, .status_bit2, .overcharge_mv, .undervoltage_mv, .overcurrent_mv,
      .low_cell_mv, .low_cell_block_on, .four_cells);
   battery_protect_config_store #(.FOUR_CELL(1'b0), .STORE_CYCLES(4)) u_dut3 (
      .sys_clk, .rst, .wake_supply_level, .sleep_req, .setup_word_write_cmd(cmd[0]),
      .control_word_write_cmd(cmd[1]), .write_enable_cmd(cmd[2]),
      .array_write_cmd(cmd[3]), .wr_data, .low_cell_flag, .overcharge_flag, .awake(),
      .protection_setup_word(word3), .control_word(), .charge_switch_ctrl(),
      .discharge_switch_ctrl(), .store_busy(), .status_bit2(), .overcharge_mv(),
      .undervoltage_mv(uv3), .overcurrent_mv(), .low_cell_mv(), .low_cell_block_on(),
      .four_cells());
   host_model #(.FOUR_CELL(1'b1)) u_host (.sys_clk, .cmd_q(cmd), .data_q(wr_data));

   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic chk_w(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic chk_all();
      #1;
      chk_w("awake", 16'(aw), {15'h0, awake});
      chk_w("word", 16'(sw), protection_setup_word);
      chk_w("ctrl", 16'(ct), control_word);
      chk_w("fets", 16'(ct[11:10]), {14'h0, discharge_switch_ctrl, charge_switch_ctrl});
      chk_w("ov", 16'(4200 + 50 * sw[15:14]), overcharge_mv);
      chk_w("uv", 16'(1950 + 100 * sw[13:12]), undervoltage_mv);
      chk_w("oc", 16'(75 + 25 * sw[11:10]), overcurrent_mv);
      chk_w("lc", 16'(500 + 300 * sw[9:8]), low_cell_mv);
      chk_w("bits", 16'({sw[7], ~sw[6]}), {14'h0, four_cells, low_cell_block_on});
      chk_w("st2", 16'((low_cell_flag & ~sw[6]) | overcharge_flag), {15'h0, status_bit2});
   endtask

   task automatic end_sim();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial
   begin
      seed = 12;
      rst = 1'b1;
      {wake_supply_level, sleep_req, low_cell_flag, overcharge_flag} = 4'h0;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      sw = 16'h33c0;
      sh = sw;
      u_host.send(0, 16'hffff);
      chk_all();
      chk_w("word3", 16'h0340, word3);
      $display("test sleep done");
      @(posedge sys_clk);
      wake_supply_level <= 1'b1;
      @(posedge sys_clk);
      aw = 1;
      chk_all();
      for (i = 0; i < 16; i++)
      begin
         r = $random(seed);
         if (i < 4)
            r[15:8] = {4{i[1:0]}};
         @(posedge sys_clk);
         {low_cell_flag, overcharge_flag} <= 2'(r[17:16]);
         u_host.send(0, r[15:0]);
         sw = r & 16'hffc0;
         chk_all();
         chk_w("uv3", 16'(2250 + 100 * sw[13:12]), uv3);
      end
      $display("test fields done");
      repeat (8) @(posedge sys_clk);
      u_host.send(1, 16'h0c00);
      ct = 16'h0c00;
      chk_all();
      u_host.send(3, 16'h1234);
      #1 chk_w("busy", 16'h0000, {15'h0, store_busy});
      u_host.send(2, 16'h0000);
      u_host.send(3, 16'(r));
      sh = sw;
      #1 chk_w("busy", 16'h0001, {15'h0, store_busy});
      u_host.send(0, 16'(~sw));
      chk_all();
      for (i = 0; i < 20 && store_busy !== 1'b0; i++)
         @(posedge sys_clk);
      if (i == 20)
      begin
         n_mismatch++;
         end_sim();
      end
      $display("test store done");
      u_host.send(0, 16'h5a80);
      sw = 16'h5a80;
      chk_all();
      @(posedge sys_clk);
      {wake_supply_level, sleep_req} <= 2'b01;
      @(posedge sys_clk);
      sleep_req <= 1'b0;
      #1 chk_w("awake", 16'h0000, {15'h0, awake});
      @(posedge sys_clk);
      wake_supply_level <= 1'b1;
      @(posedge sys_clk);
      sw = sh;
      ct = 0;
      chk_all();
      chk_w("word3", 16'(sh), word3);
      $display("test wake done");
      end_sim();
   end
endmodule
